// File: pmt_pkg.sv
// Package: constants and types for the period match timer
package pmt_pkg;
  // ----------------------------------------
  // Register indices and bus address width
  // ----------------------------------------
  localparam logic [7:0] PMT_IDX_GIC = 8'h0b;
  localparam logic [7:0] PMT_IDX_FLAGS = 8'h0c;
  localparam logic [7:0] PMT_IDX_COUNT = 8'h11;
  localparam logic [7:0] PMT_IDX_CTRL = 8'h12;
  localparam logic [7:0] PMT_IDX_ENABLES = 8'h8c;
  localparam logic [7:0] PMT_IDX_LIMIT = 8'h92;
  localparam int PMT_AW = 10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PMT_FLAG_BIT = 1;
  localparam int PMT_RUN_BIT = 2;
  localparam int PMT_PRE_LO = 0;
  localparam int PMT_POST_LO = 3;
  localparam int PMT_GIE_BIT = 7;
  localparam int PMT_PEIE_BIT = 6;
  // ----------------------------------------
  // Reset values and write masks
  // ----------------------------------------
  localparam logic [7:0] PMT_RST_COUNT = 8'h00;
  localparam logic [7:0] PMT_RST_LIMIT = 8'hff;
  localparam logic [7:0] PMT_RST_CTRL = 8'h00;
  localparam logic [7:0] PMT_RST_FLAGS = 8'h00;
  localparam logic [7:0] PMT_RST_ENABLES = 8'h00;
  localparam logic [7:0] PMT_RST_GIC = 8'h00;
  localparam logic [7:0] PMT_CTRL_MASK = 8'h7f;
  localparam logic [7:0] PMT_FLAG_MASK = 8'h02;
  // ----------------------------------------
  // Counts of cycles
  // ----------------------------------------
  localparam int PMT_CLK_NS = 4;
  localparam int PMT_INSTR_DIV = 4;
  localparam int PMT_INSTR_NS = PMT_CLK_NS * PMT_INSTR_DIV;
  localparam logic [1:0] PMT_INSTR_LAST = 2'(PMT_INSTR_NS / PMT_CLK_NS - 1);
  localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST_16 = 4'hf;

  // Prescale ratio decode
  typedef enum logic [1:0] {
    PMT_PRE_1 = 2'h0,
    PMT_PRE_4 = 2'h1,
    PMT_PRE_16 = 2'h2
  } pmt_pre_t;

  // Decoded prescaler terminal count
  function automatic logic [3:0] pmt_pre_last(input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h0;
    if (sel[1]) begin
      r = PMT_PRE_LAST_16;
    end else if (sel[0]) begin
      r = PMT_PRE_LAST_4;
    end
    return r;
  endfunction : pmt_pre_last
endpackage : pmt_pkg

// File: pmt_divider.sv
// Modulo counter producing a one-cycle tick every last+1 enables
`timescale 1ns/1ps
`default_nettype none
module pmt_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic enable,
  input wire logic [3:0] last,
  // Result
  output logic tick
);
  import pmt_pkg::*;

  logic [3:0] count;

  // Count enables, wrap at last; clear wins over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 4'h0;
    end else if (clear) begin
      count <= 4'h0;
    end else if (enable) begin
      count <= (count >= last) ? 4'h0 : 4'(count + 4'h1);
    end
  end

  // Combinational so the tick lines up with the enable that completes it
  assign tick = enable && !clear && (count >= last);
endmodule : pmt_divider
`default_nettype wire

// File: pmt_period_match_timer8.sv
// Top: 8-bit period match timer with APB register slave
// Functional notes
// R01 - Count up from zero each prescaled tick; after matching limit, next tick gives zero.
// R02 - Period limit is software read/write and resets to all ones.
// R03 - Count is software read/write and cleared by any reset.
// R04 - Count instruction clock (core clock / 4), prescaled by 1, 4 or 16.
// R05 - Match passes a 1..16 postscaler; its completion sets flag bit one.
// R06 - Writes to count or control, and reset, clear prescaler and postscaler.
// R07 - Writing control leaves the count value unchanged.
// R08 - Run bit two of control gates counting.
// R09 - Raw match pulse before the postscaler goes out for the serial port.
// R10 - Count and match are offered as the PWM time base.
// R11 - Prescale field 00 is /1, 01 is /4, 1x is /16.
// R12 - Postscale field n in bits six to three divides by n plus one.
`timescale 1ns/1ps
`default_nettype none
module pmt_period_match_timer8 (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::PMT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Time base for serial port and PWM unit
  output logic ssp_shift_tick,
  output logic [7:0] pwm_time_count,
  output logic pwm_period_match
);
  import pmt_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] period_timer_count;
  logic [7:0] period_limit;
  logic [7:0] period_timer_control;
  logic [7:0] peripheral_event_flags;
  logic [7:0] peripheral_event_enables;
  logic [7:0] global_interrupt_control;
  logic [1:0] instr_phase;
  logic instr_tick;
  logic pre_tick;
  logic post_tick;
  logic match_now;
  logic scaler_clear;
  logic wr_en;
  logic rd_en;
  logic wr_count;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_enables;
  logic wr_limit;
  logic wr_gic;
  logic addr_ok;
  logic [7:0] reg_idx;
  logic [7:0] next_rdata;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Byte address is four times the register index; low two bits must be zero
  assign reg_idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (reg_idx == PMT_IDX_GIC ||
                   reg_idx == PMT_IDX_FLAGS || reg_idx == PMT_IDX_COUNT ||
                   reg_idx == PMT_IDX_CTRL || reg_idx == PMT_IDX_ENABLES ||
                   reg_idx == PMT_IDX_LIMIT);
  // Access phase with single-cycle answer; data lives in byte lane 0
  assign wr_en = psel && penable && !pready && pwrite && addr_ok && pstrb[0];
  assign rd_en = psel && penable && !pready && !pwrite;
  assign wr_count = wr_en && (reg_idx == PMT_IDX_COUNT);
  assign wr_ctrl = wr_en && (reg_idx == PMT_IDX_CTRL);
  assign wr_flags = wr_en && (reg_idx == PMT_IDX_FLAGS);
  assign wr_enables = wr_en && (reg_idx == PMT_IDX_ENABLES);
  assign wr_limit = wr_en && (reg_idx == PMT_IDX_LIMIT);
  assign wr_gic = wr_en && (reg_idx == PMT_IDX_GIC);

  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    case (reg_idx)
      PMT_IDX_GIC: next_rdata = global_interrupt_control;
      PMT_IDX_FLAGS: next_rdata = peripheral_event_flags;
      PMT_IDX_COUNT: next_rdata = period_timer_count;
      PMT_IDX_CTRL: next_rdata = period_timer_control;
      PMT_IDX_ENABLES: next_rdata = peripheral_event_enables;
      PMT_IDX_LIMIT: next_rdata = period_limit;
      default: next_rdata = 8'h00;
    endcase
  end

  // Answer one cycle into the access phase; unmapped gives pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en) begin
        prdata <= addr_ok ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Period limit, all ones after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_limit <= PMT_RST_LIMIT; // see R02
    end else if (wr_limit) begin
      period_limit <= pwdata[7:0]; // see R02
    end
  end

  // Control; top bit is unimplemented and reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_timer_control <= PMT_RST_CTRL;
    end else if (wr_ctrl) begin
      period_timer_control <= pwdata[7:0] & PMT_CTRL_MASK;
    end
  end

  // Enables (flag bit only) steer irq; global control is plain storage that irq ignores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_event_enables <= PMT_RST_ENABLES;
      global_interrupt_control <= PMT_RST_GIC;
    end else begin
      if (wr_enables) begin
        peripheral_event_enables <= pwdata[7:0] & PMT_FLAG_MASK;
      end
      if (wr_gic) begin
        global_interrupt_control <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Clock division chain
  // ----------------------------------------
  // Instruction clock enable: core clock divided by four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= (instr_phase == PMT_INSTR_LAST) ? 2'h0 : 2'(instr_phase + 2'h1); // see R04
    end
  end
  // Stopped timer sees no enables at all, saving power in the chain
  assign instr_tick = (instr_phase == PMT_INSTR_LAST) && period_timer_control[PMT_RUN_BIT]; // see R08

  // Writes to count or control, reset via the divider's own reset, clear scalers
  assign scaler_clear = wr_count || wr_ctrl; // see R06

  // Prescaler with decoded ratio
  pmt_divider u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(scaler_clear),
    .enable(instr_tick),
    .last(pmt_pre_last(period_timer_control[PMT_PRE_LO +: 2])), // see R11
    .tick(pre_tick)
  );

  // Match fires on the tick that rolls the count back to zero
  assign match_now = pre_tick && (period_timer_count == period_limit) && !wr_count;

  // Postscaler: field n divides by n+1
  pmt_divider u_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(scaler_clear),
    .enable(match_now),
    .last(period_timer_control[PMT_POST_LO +: 4]), // see R12
    .tick(post_tick)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Software write wins; control writes leave the count alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_timer_count <= PMT_RST_COUNT; // see R03
    end else if (wr_count) begin
      period_timer_count <= pwdata[7:0]; // see R03
    end else if (pre_tick) begin
      if (period_timer_count == period_limit) begin
        period_timer_count <= 8'h00; // see R01
      end else begin
        period_timer_count <= 8'(period_timer_count + 8'h01); // see R01, R07
      end
    end
  end

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  // Sticky flag; set beats write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_event_flags <= PMT_RST_FLAGS;
    end else begin
      if (post_tick) begin
        peripheral_event_flags[PMT_FLAG_BIT] <= 1'b1; // see R05
      end else if (wr_flags && pwdata[PMT_FLAG_BIT]) begin
        peripheral_event_flags[PMT_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Level interrupt; one flop late, keeps the output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(peripheral_event_flags & peripheral_event_enables);
    end
  end

  // ----------------------------------------
  // Time base outputs
  // ----------------------------------------
  // Registered copies: one cycle behind the internal match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ssp_shift_tick <= 1'b0;
      pwm_period_match <= 1'b0;
      pwm_time_count <= 8'h00;
    end else begin
      ssp_shift_tick <= match_now; // see R09
      pwm_period_match <= match_now; // see R10
      pwm_time_count <= period_timer_count; // see R10
    end
  end
endmodule : pmt_period_match_timer8
`default_nettype wire

// File: pmt_timer_chk_asserts.sv
// Checker: port timing properties of the period match timer
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_chk (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::PMT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer side
  input wire logic irq,
  input wire logic ssp_shift_tick,
  input wire logic [7:0] pwm_time_count,
  input wire logic pwm_period_match
);
  import pmt_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer comes one cycle into the access phase and lasts one cycle
  property p_apb_answer; psel && penable && !pready |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("late bus answer");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  // Refused writes leave prdata holding the last read, so only reads are judged
  property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read not zero");
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  // Both time base consumers see the same raw match
  property p_match_same; ssp_shift_tick == pwm_period_match; endproperty
  a_match_same: assert property (p_match_same) else $error("match copies differ");
  property p_match_pulse; ssp_shift_tick |=> !ssp_shift_tick; endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match too long");
  property p_match_wrap; ssp_shift_tick |-> ##[0:2] pwm_time_count == 8'h00; endproperty
  a_match_wrap: assert property (p_match_wrap) else $error("match without wrap");
  // Bus writes excluded: a written count may jump anywhere
  property p_count_step;
    $changed(pwm_time_count) && !$past(psel)
      |-> pwm_time_count == $past(pwm_time_count) + 8'h01 || pwm_time_count == 8'h00;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count skipped");
  property p_instr_rate;
    $changed(pwm_time_count) && !psel && !$past(psel) |=> $stable(pwm_time_count) [*3];
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("count too fast");
  c_refused: cover property (pready && pslverr);
  c_match: cover property (ssp_shift_tick);
  c_irq: cover property ($rose(irq));
endmodule : pmt_timer_chk
bind pmt_period_match_timer8 pmt_timer_chk i_pmt_timer_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .ssp_shift_tick(ssp_shift_tick),
  .pwm_time_count(pwm_time_count), .pwm_period_match(pwm_period_match)
);
`default_nettype wire

// File: test_period_match_timer8.sv
// Testbench: register, prescale, postscale and stop tests of the timer
`timescale 1ns/1ps
`default_nettype none
module test_period_match_timer8;
  import pmt_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam logic [9:0] A_CNT = {PMT_IDX_COUNT, 2'b00};
  localparam logic [9:0] A_CTL = {PMT_IDX_CTRL, 2'b00};
  localparam logic [9:0] A_LIM = {PMT_IDX_LIMIT, 2'b00};
  localparam logic [9:0] A_FLG = {PMT_IDX_FLAGS, 2'b00};
  localparam logic [9:0] A_ENA = {PMT_IDX_ENABLES, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [9:0] paddr = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, tick, match;
  logic [7:0] cnt;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  pmt_period_match_timer8 i_pmt_period_match_timer8 (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ssp_shift_tick(tick), .pwm_time_count(cnt), .pwm_period_match(match));
  initial begin
    forever #2 pclk = ~pclk;
  end
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; starts on the next edge so it never re-drives in one step
  task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    // No assumed wait count; only the hang guard ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task rdchk(input logic [9:0] a, input logic [7:0] x);
    apb(0, a, 8'h00);
    chk(rd, {24'h0, x});
  endtask : rdchk
  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 5000);
  endtask : wait_tick
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rdchk(A_CNT, 8'h00);
    rdchk(A_LIM, 8'hff);
    rdchk(A_CTL, 8'h00);
    rdchk(A_FLG, 8'h00);
    rdchk(A_ENA, 8'h00);
    apb(0, 10'h3fc, 8'h00);
    chk(er, 1);
    chk(rd, 32'h0);
    apb(1, A_CNT, 8'h5a);
    rdchk(A_CNT, 8'h5a);
    apb(1, A_LIM, 8'h03);
    rdchk(A_LIM, 8'h03);
    // A write without byte lane 0 must be ignored
    pstrb <= 4'he;
    apb(1, A_LIM, 8'h77);
    pstrb <= 4'hf;
    rdchk(A_LIM, 8'h03);
    $display("register test done");
  endtask : t_reset
  // Period is four pclk per instruction, times prescale, times limit plus one
  task t_prescale;
    int n;
    apb(1, A_CNT, 8'h00);
    for (int p = 0; p < 4; p++) begin
      apb(1, A_CTL, {5'h00, 1'b1, 2'(p)});
      wait_tick(n);
      wait_tick(n);
      chk(n, 16 * (p == 0 ? 1 : (p == 1 ? 4 : 16)));
      // Time base outputs line up with the raw match
      chk(match, 1);
      chk(cnt, 8'h03);
    end
    $display("prescale test done");
  endtask : t_prescale
  // Starting from a stopped zero count keeps ticks away from the control write
  task t_postscale;
    int k, m;
    int ns[3] = '{0, 3, 15};
    apb(1, A_ENA, 8'h02);
    foreach (ns[i]) begin
      apb(1, A_CTL, 8'h00);
      apb(1, A_CNT, 8'h00);
      apb(1, A_FLG, 8'h02);
      apb(1, A_CTL, {1'b0, 4'(ns[i]), 3'b100});
      k = 0;
      m = 0;
      while (irq !== 1'b1 && m < 5000) begin
        @(posedge pclk);
        m++;
        if (tick === 1'b1) k++;
      end
      chk(k, ns[i] + 1);
    end
    rdchk(A_FLG, 8'h02);
    apb(1, A_ENA, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    $display("postscale test done");
  endtask : t_postscale
  task t_stop;
    logic [7:0] c;
    apb(1, A_CTL, 8'h00);
    // Nonzero count so a control write that cleared it would show
    apb(1, A_CNT, 8'h02);
    apb(0, A_CNT, 8'h00);
    c = rd[7:0];
    chk(c, 8'h02);
    repeat (40) @(posedge pclk);
    rdchk(A_CNT, c);
    apb(1, A_CTL, 8'hfb);
    rdchk(A_CNT, c);
    rdchk(A_CTL, 8'h7b);
    // Reset while stopped returns count and limit to their reset values
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rdchk(A_CNT, 8'h00);
    rdchk(A_LIM, 8'hff);
    $display("stop test done");
  endtask : t_stop
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_prescale();
    t_postscale();
    t_stop();
    wrap_up();
  end
endmodule : test_period_match_timer8
`default_nettype wire
